// file: include/sss_pkg.sv
// shared constants and types for the speed setpoint sources block
package sss_pkg;
  localparam int RPM_W = 16;
  localparam int TIME_W = 16;
  localparam int CFG_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_PRESET = 16;
  localparam int PRESET_AW = 4;
  localparam int N_DIRECT = 4;
  localparam int SEL_W = 4;
  localparam int THR_W = 34;
  localparam int ROUTE_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_UP_TIME = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DN_TIME = 8'h08;
  localparam logic [ADDR_W-1:0] REG_START = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CEIL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FLOOR = 8'h14;
  localparam logic [ADDR_W-1:0] REG_METHOD = 8'h18;
  localparam logic [ADDR_W-1:0] REG_MAIN_RT = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_EXTRA_RT = 8'h20;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] REG_FIXED = 8'h28;
  localparam logic [ADDR_W-1:0] REG_POT = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_PRESET_BASE = 8'h40;
  localparam logic [1:0] PRESET_PAGE = 2'h1;

  // ramped potentiometer configuration bits
  localparam int CFG_RETAIN = 0;
  localparam int CFG_AUTO_RAMP = 1;
  localparam int CFG_ROUND = 2;
  localparam int CFG_PERSIST = 3;
  localparam int CFG_ALWAYS = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h06;

  // status bits
  localparam int ST_FIXED_SEL = 0;
  localparam int ST_POT_ON = 1;

  // timing
  localparam int RAMP_DEFAULT_S = 10;
  localparam int MS_PER_S = 1000;
  localparam logic [TIME_W-1:0] RAMP_DEFAULT_MS = TIME_W'(RAMP_DEFAULT_S * MS_PER_S);
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CYC_PER_MS_DEFAULT = MS_NS / CLK_PERIOD_NS;
  localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
  localparam int ROUND_STEPS = 16;

  // speed defaults in rpm
  localparam logic signed [RPM_W-1:0] START_DEFAULT = 16'sh0000;
  localparam logic signed [RPM_W-1:0] CEIL_DEFAULT = 16'sh0000;
  localparam logic signed [RPM_W-1:0] FLOOR_DEFAULT = 16'sh0000;
  localparam logic signed [RPM_W-1:0] RPM_ZERO = 16'sh0000;
  localparam logic signed [RPM_W-1:0] RPM_ONE = 16'sh0001;

  // source codes: 1050 potentiometer, 1024 fixed speeds
  localparam logic [ROUTE_W-1:0] ROUTE_NONE = 16'h0000;
  localparam logic [ROUTE_W-1:0] ROUTE_POT = 16'h041a;
  localparam logic [ROUTE_W-1:0] ROUTE_FIXED = 16'h0400;

  typedef enum logic [1:0] {
    SSS_DIRECT = 2'b01,
    SSS_BINARY = 2'b10
  } sss_method_type;

  typedef enum logic [0:0] {
    SSS_POT_OFF = 1'b0,
    SSS_POT_ON = 1'b1
  } sss_pot_state_type;
endpackage

// file: rtl/sss_preset_mem.sv
// fixed speed preset store with two registered read ports
`timescale 1ns/1ps
module sss_preset_mem #(
  parameter int W = 16,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] ra_addr_i,
  output logic [W-1:0] ra_data_o,
  input wire logic [AW-1:0] rb_addr_i,
  output logic [W-1:0] rb_data_o
);
  logic [W-1:0] mem_ff [2**AW];

  // presets power up at zero rpm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ra_data_o <= '0;
      rb_data_o <= '0;
    end else begin
      ra_data_o <= mem_ff[ra_addr_i];
      rb_data_o <= mem_ff[rb_addr_i];
    end
  end
endmodule

// file: rtl/sss_top.sv
// speed setpoint sources: ramped up/down setpoint and fixed speed selector
`timescale 1ns/1ps
// Behaviour
// RQ1: raise command ramps up, lower ramps down
// RQ2: separate up and down ramp times, 10 s
// RQ3: start value in rpm, default zero
// RQ4: five configuration bits, default 00110
// RQ5: start value or saved value at switch-on
// RQ6: automatic mode without ramp when bit01 clear
// RQ7: manual mode always ramps; a zero ramp time jumps straight to the limit instead
// RQ8: bit02 gives gentle initial rounding
// RQ9: bit03 with bit00 stores across power loss
// RQ10: bit04 clear updates only with pulses enabled
// RQ11: ceiling and floor speeds, default zero
// RQ12: rising accept edge loads preset value
// RQ13: preset value comes from its own input
// RQ14: main setpoint routable to potentiometer, 1050
// RQ15: both setpoints routable to fixed speeds, 1024
// RQ16: direct mode sums the selected presets
// RQ17: select bit n enables preset n+1
// RQ18: binary mode picks one of sixteen
// RQ19: method 1 direct, 2 binary, default direct
// RQ20: flag high while any preset selected
// RQ21: clamp after each step, hold when idle
// RQ22: per-clock increment from time and ceiling
module sss_top
  import sss_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic motor_on_i,
  input wire logic pulses_en_i,
  input wire logic auto_manual_select_i,
  input wire logic pot_raise_cmd_i,
  input wire logic pot_lower_cmd_i,
  input wire logic pot_accept_preset_i,
  input wire logic signed [RPM_W-1:0] pot_preset_value_i,
  input wire logic fixed_select_bit0_i,
  input wire logic fixed_select_bit1_i,
  input wire logic fixed_select_bit2_i,
  input wire logic fixed_select_bit3_i,
  output logic signed [RPM_W-1:0] ramped_updown_setpoint_o,
  output logic signed [RPM_W-1:0] fixed_speed_result_o,
  output logic fixed_selected_flag_o,
  output logic signed [RPM_W-1:0] main_setpoint_o,
  output logic signed [RPM_W-1:0] extra_setpoint_o,
  output logic persist_wr_o,
  output logic signed [RPM_W-1:0] persist_data_o
);
  function automatic logic signed [RPM_W-1:0] clamp_rpm(input logic signed [RPM_W-1:0] v,
      input logic signed [RPM_W-1:0] lo, input logic signed [RPM_W-1:0] hi);
    if (v > hi) begin
      return hi;
    end else if (v < lo) begin
      return lo;
    end
    return v;
  endfunction

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] nw,
      input logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic signed [RPM_W-1:0] route_pick(input logic [ROUTE_W-1:0] rt,
      input logic signed [RPM_W-1:0] pot, input logic signed [RPM_W-1:0] fixed);
    if (rt == ROUTE_POT) begin
      return pot;
    end else if (rt == ROUTE_FIXED) begin
      return fixed;
    end
    return RPM_ZERO;
  endfunction

  function automatic logic signed [RPM_W+1:0] clamp_wide(input logic signed [RPM_W+1:0] v);
    if (v > (RPM_W+2)'(16'sh7fff)) begin
      return (RPM_W+2)'(16'sh7fff);
    end else if (v < (RPM_W+2)'(16'sh8000)) begin
      return (RPM_W+2)'(16'sh8000);
    end
    return v;
  endfunction

  // software registers
  logic [CFG_W-1:0] cfg_ff;
  logic [TIME_W-1:0] up_time_ff;
  logic [TIME_W-1:0] dn_time_ff;
  logic signed [RPM_W-1:0] start_ff;
  logic signed [RPM_W-1:0] ceil_ff;
  logic signed [RPM_W-1:0] floor_ff;
  sss_method_type method_ff;
  logic [ROUTE_W-1:0] main_rt_ff;
  logic [ROUTE_W-1:0] extra_rt_ff;
  logic ack_ff;
  logic preset_rd_ff;
  logic [DATA_W-1:0] dat_ff;

  // potentiometer state
  sss_pot_state_type pot_state_ff;
  logic motor_q_ff;
  logic accept_q_ff;
  logic signed [RPM_W-1:0] pot_ff;
  logic signed [RPM_W-1:0] nxt_pot;
  logic signed [RPM_W-1:0] stored_ff;
  logic [THR_W-1:0] acc_ff;
  logic [THR_W-1:0] nxt_acc;
  logic [4:0] round_cnt_ff;

  // fixed speed state
  logic [1:0] scan_ff;
  logic [PRESET_AW-1:0] addr_q_ff;
  logic binary_q_ff;
  logic signed [RPM_W+1:0] sum_ff;
  logic signed [RPM_W-1:0] fixed_ff;
  logic flag_ff;
  logic [RPM_W-1:0] ra_data;
  logic [RPM_W-1:0] rb_data;

  logic bus_req;
  logic bus_wr;
  logic preset_hit;
  logic [SEL_W-1:0] sel;
  logic on_rise;
  logic off_fall;
  logic accept_rise;
  logic upd_en;
  logic dir_up;
  logic dir_dn;
  logic immediate;
  logic rounding;
  logic step_fire;
  logic signed [RPM_W-1:0] target;
  logic [TIME_W-1:0] ramp_ms;
  logic [RPM_W-1:0] rate;
  logic [THR_W-1:0] thr;
  logic [THR_W-1:0] acc_sum;
  logic signed [RPM_W+1:0] term;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_wr = bus_req & wb_we_i;
  assign preset_hit = wb_adr_i[7:6] == PRESET_PAGE;
  assign sel = {fixed_select_bit3_i, fixed_select_bit2_i, fixed_select_bit1_i,
                fixed_select_bit0_i};
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = preset_rd_ff ? {{(DATA_W-RPM_W){1'b0}}, rb_data} : dat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      preset_rd_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
      preset_rd_ff <= bus_req & preset_hit;
    end
  end

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // RQ4: configuration reset pattern
      cfg_ff <= CFG_RESET;
      // RQ2: both ramp times ten seconds
      up_time_ff <= RAMP_DEFAULT_MS;
      dn_time_ff <= RAMP_DEFAULT_MS;
      // RQ3: start value zero rpm
      start_ff <= START_DEFAULT;
      // RQ11: speed limits zero rpm
      ceil_ff <= CEIL_DEFAULT;
      floor_ff <= FLOOR_DEFAULT;
      // RQ19: direct selection after reset
      method_ff <= SSS_DIRECT;
      main_rt_ff <= ROUTE_NONE;
      extra_rt_ff <= ROUTE_NONE;
    end else if (bus_wr) begin
      case (wb_adr_i)
        REG_CFG: begin
          if (wb_sel_i[0]) begin
            cfg_ff <= wb_dat_i[CFG_W-1:0];
          end
        end
        REG_UP_TIME: up_time_ff <= be_merge(up_time_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_DN_TIME: dn_time_ff <= be_merge(dn_time_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_START: start_ff <= be_merge(start_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_CEIL: ceil_ff <= be_merge(ceil_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_FLOOR: floor_ff <= be_merge(floor_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_METHOD: begin
          // RQ19: only codes 1 and 2 accepted
          if (wb_sel_i[0] && (wb_dat_i[1:0] == SSS_DIRECT || wb_dat_i[1:0] == SSS_BINARY)) begin
            method_ff <= sss_method_type'(wb_dat_i[1:0]);
          end
        end
        REG_MAIN_RT: main_rt_ff <= be_merge(main_rt_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        REG_EXTRA_RT: extra_rt_ff <= be_merge(extra_rt_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (bus_req) begin
      case (wb_adr_i)
        REG_CFG: dat_ff <= {{(DATA_W-CFG_W){1'b0}}, cfg_ff};
        REG_UP_TIME: dat_ff <= {16'h0000, up_time_ff};
        REG_DN_TIME: dat_ff <= {16'h0000, dn_time_ff};
        REG_START: dat_ff <= {16'h0000, start_ff};
        REG_CEIL: dat_ff <= {16'h0000, ceil_ff};
        REG_FLOOR: dat_ff <= {16'h0000, floor_ff};
        REG_METHOD: dat_ff <= {30'h0, method_ff};
        REG_MAIN_RT: dat_ff <= {16'h0000, main_rt_ff};
        REG_EXTRA_RT: dat_ff <= {16'h0000, extra_rt_ff};
        REG_STATUS: dat_ff <= {30'h0, pot_state_ff == SSS_POT_ON, flag_ff};
        REG_FIXED: dat_ff <= {16'h0000, fixed_ff};
        REG_POT: dat_ff <= {16'h0000, pot_ff};
        default: dat_ff <= '0;
      endcase
    end
  end

  sss_preset_mem #(.W(RPM_W), .AW(PRESET_AW)) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(bus_wr & preset_hit & (&wb_sel_i[1:0])),
    .wr_addr_i(wb_adr_i[5:2]),
    .wr_data_i(wb_dat_i[RPM_W-1:0]),
    // RQ18: binary index drives the read address
    .ra_addr_i(method_ff == SSS_BINARY ? sel : {2'b00, scan_ff}),
    .ra_data_o(ra_data),
    .rb_addr_i(wb_adr_i[5:2]),
    .rb_data_o(rb_data)
  );

  // potentiometer command decode
  assign on_rise = motor_on_i & ~motor_q_ff;
  assign off_fall = ~motor_on_i & motor_q_ff;
  assign accept_rise = pot_accept_preset_i & ~accept_q_ff;
  // RQ10: pulse enable gating unless bit04
  assign upd_en = cfg_ff[CFG_ALWAYS] | pulses_en_i;
  assign dir_up = pot_raise_cmd_i & ~pot_lower_cmd_i;
  assign dir_dn = pot_lower_cmd_i & ~pot_raise_cmd_i;
  assign target = dir_up ? ceil_ff : floor_ff;
  assign ramp_ms = dir_up ? up_time_ff : dn_time_ff;
  // RQ6: automatic mode bypasses ramp without bit01
  // RQ7: manual mode keeps the ramp unless the ramp time is zero
  assign immediate = (auto_manual_select_i & ~cfg_ff[CFG_AUTO_RAMP]) | (ramp_ms == TIME_ZERO);
  // RQ8: halve the rate for the first steps
  assign rounding = cfg_ff[CFG_ROUND] & (round_cnt_ff < 5'(ROUND_STEPS));
  assign rate = (ceil_ff < 0) ? RPM_W'(-ceil_ff) : ((ceil_ff == 0) ? RPM_ONE : ceil_ff);
  // RQ22: threshold is ramp time in clocks
  assign thr = (THR_W'(ramp_ms) * THR_W'(CYC_PER_MS)) << rounding;
  assign acc_sum = acc_ff + THR_W'(rate);
  assign step_fire = (pot_state_ff == SSS_POT_ON) & upd_en & (dir_up | dir_dn) & ~immediate
                     & ~accept_rise & (acc_sum >= thr) & (pot_ff != target);

  always_comb begin
    nxt_pot = pot_ff;
    nxt_acc = '0;
    if (on_rise) begin
      // RQ5: restore saved value or load start value
      // RQ3: start value taken at switch-on
      nxt_pot = cfg_ff[CFG_RETAIN] ? stored_ff : clamp_rpm(start_ff, floor_ff, ceil_ff);
    end else if (pot_state_ff == SSS_POT_ON && upd_en) begin
      if (accept_rise) begin
        // RQ12: preset taken on rising edge
        // RQ13: value from preset input
        nxt_pot = clamp_rpm(pot_preset_value_i, floor_ff, ceil_ff);
      end else if ((dir_up || dir_dn) && immediate) begin
        nxt_pot = clamp_rpm(target, floor_ff, ceil_ff);
      end else if (dir_up || dir_dn) begin
        nxt_acc = acc_sum;
        if (step_fire) begin
          // RQ1: one rpm towards the commanded limit
          // RQ21: clamp after each step
          nxt_pot = clamp_rpm(dir_up ? pot_ff + RPM_ONE : pot_ff - RPM_ONE, floor_ff, ceil_ff);
          nxt_acc = acc_sum - thr;
        end else if (pot_ff == target) begin
          nxt_acc = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pot_state_ff <= SSS_POT_OFF;
      motor_q_ff <= 1'b0;
      accept_q_ff <= 1'b0;
      pot_ff <= RPM_ZERO;
      acc_ff <= '0;
    end else begin
      pot_state_ff <= motor_on_i ? SSS_POT_ON : SSS_POT_OFF;
      motor_q_ff <= motor_on_i;
      accept_q_ff <= pot_accept_preset_i;
      pot_ff <= nxt_pot;
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      round_cnt_ff <= '0;
    end else if (!(dir_up || dir_dn)) begin
      round_cnt_ff <= '0;
    end else if (step_fire && round_cnt_ff < 5'(ROUND_STEPS)) begin
      round_cnt_ff <= round_cnt_ff + 5'h01;
    end
  end

  // saved value and external store request at switch-off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stored_ff <= RPM_ZERO;
      persist_wr_o <= 1'b0;
      persist_data_o <= RPM_ZERO;
    end else begin
      persist_wr_o <= 1'b0;
      if (off_fall && cfg_ff[CFG_RETAIN]) begin
        stored_ff <= pot_ff;
        // RQ9: nonvolatile store only with bit03 and bit00
        persist_wr_o <= cfg_ff[CFG_PERSIST];
        persist_data_o <= pot_ff;
      end
    end
  end

  // fixed speeds: direct mode scans four presets, one per clock, result every four clocks; binary mode updates every clock
  // RQ17: select bit n gates preset n+1
  assign term = sel[addr_q_ff[1:0]] ? (RPM_W+2)'(signed'(ra_data)) : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_ff <= '0;
      addr_q_ff <= '0;
      binary_q_ff <= 1'b0;
      sum_ff <= '0;
      fixed_ff <= RPM_ZERO;
    end else begin
      scan_ff <= scan_ff + 2'h1;
      addr_q_ff <= (method_ff == SSS_BINARY) ? sel : {2'b00, scan_ff};
      binary_q_ff <= method_ff == SSS_BINARY;
      if (binary_q_ff) begin
        fixed_ff <= signed'(ra_data);
        sum_ff <= '0;
      end else if (addr_q_ff[1:0] == 2'(N_DIRECT - 1)) begin
        // RQ16: sum of enabled presets, saturated
        fixed_ff <= RPM_W'(clamp_wide(sum_ff + term));
        sum_ff <= '0;
      end else begin
        sum_ff <= sum_ff + term;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
      main_setpoint_o <= RPM_ZERO;
      extra_setpoint_o <= RPM_ZERO;
    end else begin
      // RQ20: any selection bit set
      flag_ff <= sel != 4'h0;
      // RQ14: main route to the potentiometer
      // RQ15: either route to the fixed speeds
      main_setpoint_o <= route_pick(main_rt_ff, pot_ff, fixed_ff);
      extra_setpoint_o <= route_pick(extra_rt_ff, pot_ff, fixed_ff);
    end
  end

  assign ramped_updown_setpoint_o = pot_ff;
  assign fixed_speed_result_o = fixed_ff;
  assign fixed_selected_flag_o = flag_ff;

  sequence idle_on_s;
    motor_on_i && motor_q_ff && !pot_raise_cmd_i && !pot_lower_cmd_i && !accept_rise;
  endsequence

  sequence switch_on_s;
    motor_on_i && !motor_q_ff;
  endsequence

  hold_when_idle_a: assert property ( // RQ21
    @(posedge clk_i) disable iff (rst_i) idle_on_s ##1 motor_on_i |-> $stable(pot_ff))
    else $error("potentiometer moved with no command");

  start_load_a: assert property ( // RQ5
    @(posedge clk_i) disable iff (rst_i) switch_on_s and !cfg_ff[CFG_RETAIN]
    |=> pot_ff == clamp_rpm($past(start_ff), $past(floor_ff), $past(ceil_ff)))
    else $error("start value not loaded at switch-on");

  restore_saved_a: assert property ( // RQ5
    @(posedge clk_i) disable iff (rst_i) switch_on_s and cfg_ff[CFG_RETAIN]
    |=> pot_ff == $past(stored_ff))
    else $error("saved value not restored at switch-on");

  preset_accept_a: assert property ( // RQ12
    @(posedge clk_i) disable iff (rst_i) motor_on_i && motor_q_ff && upd_en && accept_rise
    |=> pot_ff == clamp_rpm($past(pot_preset_value_i), $past(floor_ff), $past(ceil_ff)))
    else $error("preset not taken on accept edge");

  auto_jump_a: assert property ( // RQ6
    @(posedge clk_i) disable iff (rst_i) motor_on_i && motor_q_ff && upd_en && dir_up
    && !accept_rise && auto_manual_select_i && !cfg_ff[CFG_AUTO_RAMP] && floor_ff <= ceil_ff
    |=> pot_ff == $past(ceil_ff))
    else $error("automatic mode did not jump to ceiling");

  pulse_gate_a: assert property ( // RQ10
    @(posedge clk_i) disable iff (rst_i) motor_on_i && motor_q_ff && !pulses_en_i
    && !cfg_ff[CFG_ALWAYS] |=> $stable(pot_ff))
    else $error("setpoint changed without pulse enable");

  step_clamped_a: assert property ( // RQ21
    @(posedge clk_i) disable iff (rst_i) step_fire && floor_ff <= ceil_ff
    |=> pot_ff >= $past(floor_ff) && pot_ff <= $past(ceil_ff))
    else $error("ramp step left the speed limits");

  raise_rises_a: assert property ( // RQ1
    @(posedge clk_i) disable iff (rst_i) step_fire && dir_up && pot_ff < ceil_ff
    |=> pot_ff == $past(pot_ff) + RPM_ONE)
    else $error("raise step not one rpm up");

  persist_store_a: assert property ( // RQ9
    @(posedge clk_i) disable iff (rst_i) off_fall && cfg_ff[CFG_RETAIN]
    |=> persist_wr_o == $past(cfg_ff[CFG_PERSIST]) && persist_data_o == $past(pot_ff))
    else $error("store request wrong at switch-off");

  selected_flag_a: assert property ( // RQ20
    @(posedge clk_i) disable iff (rst_i) ##1 fixed_selected_flag_o == ($past(sel) != 4'h0))
    else $error("fixed selection flag wrong");

  main_route_a: assert property ( // RQ14
    @(posedge clk_i) disable iff (rst_i) main_rt_ff == ROUTE_POT |=> main_setpoint_o == $past(pot_ff))
    else $error("main setpoint not following potentiometer");
endmodule

// file: verif/sss_cmd_source.sv
// control signal source standing in for digital inputs or fieldbus
`timescale 1ns/1ps
module sss_cmd_source
  import sss_pkg::*;
(
  input wire logic clk_i,
  input wire logic [9:0] cmd_i,
  input wire logic signed [RPM_W-1:0] val_i,
  output logic [9:0] cmd_o,
  output logic signed [RPM_W-1:0] val_o
);
  // commands change only just after a rising edge
  always_ff @(posedge clk_i) begin
    cmd_o <= cmd_i;
    val_o <= val_i;
  end
endmodule

// file: verif/test_sss_top.sv
// self-checking bench for the speed setpoint sources block
`timescale 1ns/1ps
module test_sss_top;
  import sss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [DATA_W-1:0] dw = 32'h0, dr;
  logic [9:0] cmd = 10'h000, c;
  logic signed [RPM_W-1:0] val = 16'sh0000, v;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o, flag, pwr;
  logic signed [RPM_W-1:0] pot, fix, mainsp, extra, pdat;
  int fails = 0, total_checks = 0, cycles = 0;
  int stores = 0;
  sss_cmd_source u_sss_cmd_source (.clk_i(clk_i), .cmd_i(cmd), .val_i(val), .cmd_o(c), .val_o(v));
  sss_top #(.CYC_PER_MS(4)) u_sss_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motor_on_i(c[9]), .pulses_en_i(c[8]),
    .auto_manual_select_i(c[7]), .pot_raise_cmd_i(c[6]), .pot_lower_cmd_i(c[5]),
    .pot_accept_preset_i(c[4]), .pot_preset_value_i(v), .fixed_select_bit0_i(c[0]),
    .fixed_select_bit1_i(c[1]), .fixed_select_bit2_i(c[2]), .fixed_select_bit3_i(c[3]),
    .ramped_updown_setpoint_o(pot), .fixed_speed_result_o(fix),
    .fixed_selected_flag_o(flag), .main_setpoint_o(mainsp), .extra_setpoint_o(extra),
    .persist_wr_o(pwr), .persist_data_o(pdat));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // counts store request pulses
  always @(posedge clk_i) begin
    if (pwr === 1'b1) begin
      stores <= stores + 1;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus_sel(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    dr = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_sel(w, a, d, 4'hf);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task reg_defaults;
    bus(1'b0, REG_CFG, 32'h0);
    chk(dr, 32'h6);
    bus(1'b0, REG_UP_TIME, 32'h0);
    chk(dr, 32'd10000);
    bus(1'b0, REG_DN_TIME, 32'h0);
    chk(dr, 32'd10000);
    bus(1'b0, REG_START, 32'h0);
    chk(dr, 32'h0);
    bus(1'b0, REG_CEIL, 32'h0);
    chk(dr, 32'h0);
    bus(1'b0, REG_METHOD, 32'h0);
    chk(dr, 32'h1);
    bus(1'b0, REG_FLOOR, 32'h0);
    chk(dr, 32'h0);
    bus(1'b0, 8'h3c, 32'h0);
    chk(dr, 32'h0);
    // only the enabled byte lane lands
    bus_sel(1'b1, REG_FLOOR, 32'h1234, 4'h2);
    bus(1'b0, REG_FLOOR, 32'h0);
    chk(dr, 32'h1200);
    bus(1'b1, REG_FLOOR, 32'h0);
    // preset write needs both low lanes
    bus_sel(1'b1, REG_PRESET_BASE, 32'd55, 4'h1);
    bus(1'b0, REG_PRESET_BASE, 32'h0);
    chk(dr, 32'h0);
  endtask
  task fixed_direct;
    bus(1'b1, REG_PRESET_BASE, 32'd100);
    bus(1'b1, REG_PRESET_BASE + 8'h04, 32'd200);
    bus(1'b1, REG_PRESET_BASE + 8'h08, 32'd400);
    bus(1'b1, REG_PRESET_BASE + 8'h0c, 32'd800);
    bus(1'b1, REG_MAIN_RT, {16'h0, ROUTE_FIXED});
    bus(1'b1, REG_EXTRA_RT, {16'h0, ROUTE_FIXED});
    chk({31'h0, flag}, 32'h0);
    @(posedge clk_i);
    cmd <= 10'h305;
    wait_n(12);
    chk(32'(fix), 32'd500);
    chk({31'h0, flag}, 32'h1);
    chk(32'(mainsp), 32'd500);
    chk(32'(extra), 32'd500);
    cmd <= 10'h30a;
    wait_n(12);
    chk(32'(fix), 32'd1000);
  endtask
  task fixed_binary;
    bus(1'b1, REG_PRESET_BASE + 8'h24, 32'd777);
    bus(1'b1, REG_METHOD, 32'h2);
    @(posedge clk_i);
    cmd <= 10'h309;
    wait_n(12);
    chk(32'(fix), 32'd777);
    bus(1'b0, REG_FIXED, 32'h0);
    chk(dr, 32'd777);
    bus(1'b0, REG_PRESET_BASE + 8'h24, 32'h0);
    chk(dr, 32'd777);
    bus(1'b1, REG_METHOD, 32'h3);
    bus(1'b0, REG_METHOD, 32'h0);
    chk(dr, 32'h2);
  endtask
  task pot_ramp;
    bus(1'b1, REG_CEIL, 32'd1000);
    bus(1'b1, REG_START, 32'd100);
    bus(1'b1, REG_UP_TIME, 32'h0);
    bus(1'b1, REG_MAIN_RT, {16'h0, ROUTE_POT});
    // motor was left on: switch off first so the start value loads
    @(posedge clk_i);
    cmd <= 10'h000;
    wait_n(4);
    cmd <= 10'h300;
    wait_n(4);
    chk(32'(pot), 32'd100);
    chk(32'(mainsp), 32'd100);
    cmd <= 10'h340;
    wait_n(4);
    chk(32'(pot), 32'd1000);
    cmd <= 10'h300;
    val <= 16'sd300;
    wait_n(2);
    cmd <= 10'h310;
    wait_n(4);
    chk(32'(pot), 32'd300);
  endtask
  // 1000 ms at 4 clocks/ms, ceiling 1000: one rpm per 8 clocks with rounding, per 4 clocks without
  task pot_slew;
    bus(1'b1, REG_UP_TIME, 32'd1000);
    @(posedge clk_i);
    cmd <= 10'h340;
    wait_n(42);
    cmd <= 10'h300;
    wait_n(4);
    chk(32'(pot), 32'd305);
    bus(1'b1, REG_CFG, 32'h0);
    @(posedge clk_i);
    cmd <= 10'h340;
    wait_n(42);
    cmd <= 10'h300;
    wait_n(4);
    chk(32'(pot), 32'd315);
    @(posedge clk_i);
    cmd <= 10'h320;
    wait_n(82);
    cmd <= 10'h300;
    wait_n(4);
    chk(32'(pot), 32'd313);
  endtask
  task pot_modes;
    @(posedge clk_i);
    cmd <= 10'h2c0;
    wait_n(6);
    chk(32'(pot), 32'd313);
    bus(1'b1, REG_CFG, 32'h10);
    wait_n(4);
    chk(32'(pot), 32'd1000);
    bus(1'b1, REG_CFG, 32'h19);
    @(posedge clk_i);
    cmd <= 10'h000;
    wait_n(4);
    chk(stores, 32'd1);
    chk(32'(pdat), 32'd1000);
    cmd <= 10'h300;
    wait_n(4);
    chk(32'(pot), 32'd1000);
    bus(1'b1, REG_CFG, 32'h11);
    @(posedge clk_i);
    cmd <= 10'h000;
    wait_n(4);
    chk(stores, 32'd1);
  endtask
  initial begin
    wait_n(10);
    rst_i <= 1'b0;
    wait_n(2);
    reg_defaults();
    fixed_direct();
    fixed_binary();
    pot_ramp();
    pot_slew();
    pot_modes();
    complete_run();
  end
endmodule
